// ### tbv_pkg.sv
// package: constants for the trip, bypass and voting block
package tbv_pkg;
  // ====================
  // geometry
  localparam int NUM_CHANNELS = 12;
  localparam int NUM_DIVISIONS = 4;
  localparam int NUM_GROUPS = 4;
  localparam int CH_PER_DIV = 3;
  localparam int POWER_W = 16;
  localparam int VOTE_NEEDED = 2;
  // ====================
  // timing
  localparam longint CLK_HZ = 10000000;
  localparam longint RESET_INHIBIT_S = 10;
  localparam longint RESET_INHIBIT_CYCLES = RESET_INHIBIT_S * CLK_HZ;
  // ====================
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CH_BYPASS = 8'h00;
  localparam logic [7:0] REG_DIV_BYPASS = 8'h04;
  localparam logic [7:0] REG_THRESH_NORMAL = 8'h08;
  localparam logic [7:0] REG_THRESH_NONCOINC = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_INT_STATUS = 8'h14;
  localparam logic [7:0] REG_INT_MASK = 8'h18;
  localparam logic [7:0] REG_DIV_POWER01 = 8'h1c;
  localparam logic [7:0] REG_DIV_POWER23 = 8'h20;
  localparam logic [7:0] REG_BYPASS_GRANT = 8'h24;
  // ====================
  // reset values
  localparam logic [15:0] THRESH_NORMAL_RST = 16'hc000;
  localparam logic [15:0] THRESH_NONCOINC_RST = 16'h4000;
  // ====================
  // interrupt status bit positions
  localparam int IRQ_SCRAM = 0;
  localparam int IRQ_BACKUP = 1;
  localparam int IRQ_LATCH_A = 2;
  localparam int IRQ_LATCH_B = 3;
  localparam int IRQ_BYP_REJECT = 4;
  localparam int IRQ_W = 5;
endpackage

// ### tbv_inhibit_timer.sv
// module: per-division reset inhibit timer
module tbv_inhibit_timer #(
  parameter longint CYCLES = tbv_pkg::RESET_INHIBIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic restart_i,
  output logic busy_o
);
  logic [31:0] count;

  // ====================
  // counter restarts on each new latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (restart_i) begin
      count <= 32'(CYCLES); // see RL19
    end else if (count != '0) begin
      count <= count - 32'h1;
    end
  end

  assign busy_o = (count != '0); // see RL17
endmodule

// ### tbv_trip_voting.sv
// module: source-range bypass, divisional voting and sealed trip actuators
// Behaviour
// RL1: twelve channels map to four bypass groups, each a distinct subset
// RL2: at most one bypassed channel per group, so four at most
// RL3: divisional bypass removes one division's trip module entirely
// RL4: channel bypasses never stop two-out-of-four divisional voting
// RL5: source-range and average-power bypasses stay independent
// RL6: channel powers of a division are combined and averaged
// RL7: source-range trips act only while mode selector is not Run
// RL8: non-coincident mode uses lower upscale trip threshold
// RL9: source-range permissives go out to boron injection system
// RL10: failed unbypassed channel trips only its own division
// RL11: full scram needs divisional trips in two of four divisions
// RL12: bypassed channel gives no trip; others keep protecting
// RL13: both actuator divisions see all four divisions; two trip scram
// RL14: backup drivers energise air dump solenoids, voted two of four
// RL15: actuator divisions latch trips; manual reset clears its division
// RL16: reset ignored while a trip cause is still present
// RL17: all manual resets blocked ten seconds after a trip
// RL18: rod hydraulic unit scrams only with both solenoids de-energised
// RL19: inhibit interval counted on system clock, restarted per new latch
module tbv_trip_voting #(
  parameter longint INHIBIT_CYCLES = tbv_pkg::RESET_INHIBIT_CYCLES,
  parameter int POWER_W = tbv_pkg::POWER_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  // channel inputs (from channel electronics)
  input wire logic [11:0] channel_fault_i,
  input wire logic [12*POWER_W-1:0] channel_power_i,
  // operator switches (pins)
  input wire logic [11:0] channel_bypass_sw_i,
  input wire logic [3:0] div_bypass_sw_i,
  input wire logic mode_run_i,
  input wire logic noncoincident_i,
  input wire logic [1:0] manual_reset_i,
  // outputs to actuators
  output logic [1:0] primary_trip_o,
  output logic [1:0] load_driver_energise_o,
  output logic backup_dump_energise_o,
  output logic [3:0] div_trip_o,
  output logic transient_permissive_o
);
  localparam int PW = POWER_W;

  // ====================
  // channel to division / group map
  // division d holds channels d, d+4, d+8; group g holds channels 3g..3g+2,
  // so each group spans three divisions and a group bypass never empties one
  function automatic logic [1:0] div_of(input int ch);
    return 2'(ch % 4);
  endfunction

  function automatic logic [1:0] group_of(input int ch);
    return 2'(ch / 3); // see RL1
  endfunction

  function automatic logic vote2(input logic [3:0] v);
    return (32'(v[0]) + 32'(v[1]) + 32'(v[2]) + 32'(v[3])) >= 32'(tbv_pkg::VOTE_NEEDED);
  endfunction

  // ====================
  // pin synchronisers
  logic [11:0] byp_s1, byp_s2;
  logic [3:0] dbyp_s1, dbyp_s2;
  logic [1:0] rst_s1, rst_s2;
  logic run_s1, run_s2, nc_s1, nc_s2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byp_s1 <= '0;
      byp_s2 <= '0;
      dbyp_s1 <= '0;
      dbyp_s2 <= '0;
      rst_s1 <= '0;
      rst_s2 <= '0;
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      nc_s1 <= 1'b0;
      nc_s2 <= 1'b0;
    end else begin
      byp_s1 <= channel_bypass_sw_i;
      byp_s2 <= byp_s1;
      dbyp_s1 <= div_bypass_sw_i;
      dbyp_s2 <= dbyp_s1;
      rst_s1 <= manual_reset_i;
      rst_s2 <= rst_s1;
      run_s1 <= mode_run_i;
      run_s2 <= run_s1;
      nc_s1 <= noncoincident_i;
      nc_s2 <= nc_s1;
    end
  end

  // ====================
  // registers
  logic [11:0] sw_bypass;
  logic [3:0] sw_div_bypass;
  logic [15:0] thresh_normal, thresh_noncoinc;
  logic [tbv_pkg::IRQ_W-1:0] int_status, int_mask;

  // ====================
  // channel bypass grant: first requester wins inside each group
  logic [11:0] bypass_req, bypass_grant, next_grant;
  logic byp_reject;
  assign bypass_req = byp_s2 | sw_bypass;

  always_comb begin
    logic [3:0] taken;
    taken = '0;
    next_grant = '0;
    byp_reject = 1'b0;
    for (int c = 0; c < 12; c++) begin
      if (bypass_req[c]) begin
        if (!taken[group_of(c)]) begin
          next_grant[c] = bypass_grant[c] | !(|(bypass_grant & bypass_req & grp_mask(c)));
          taken[group_of(c)] = next_grant[c];
        end
        if (!next_grant[c]) begin
          byp_reject = 1'b1; // see RL2
        end
      end
    end
  end

  function automatic logic [11:0] grp_mask(input int ch);
    logic [11:0] m;
    m = '0;
    for (int k = 0; k < 12; k++) begin
      m[k] = (group_of(k) == group_of(ch));
    end
    return m;
  endfunction

  // existing grants hold; a new one is taken only if the group is free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bypass_grant <= '0;
    end else begin
      bypass_grant <= next_grant; // see RL2
    end
  end

  // ====================
  // channel trips and divisional power
  logic [15:0] threshold;
  logic [11:0] chan_trip;
  logic [3:0] div_raw_trip, div_trip;
  logic [PW+1:0] div_sum [4];
  logic [PW-1:0] div_power [4];

  assign threshold = nc_s2 ? thresh_noncoinc : thresh_normal; // see RL8

  always_comb begin
    for (int c = 0; c < 12; c++) begin
      // bypassed channel neither trips nor votes; others carry on
      chan_trip[c] = !bypass_grant[c] && (channel_fault_i[c] ||
        (32'(channel_power_i[c*PW +: PW]) >= 32'(threshold))); // see RL12 RL10
    end
  end

  always_comb begin
    for (int d = 0; d < 4; d++) begin
      div_sum[d] = '0;
      div_raw_trip[d] = 1'b0;
    end
    for (int c = 0; c < 12; c++) begin
      div_sum[div_of(c)] = div_sum[div_of(c)] + (PW+2)'(channel_power_i[c*PW +: PW]); // see RL6
      div_raw_trip[div_of(c)] = div_raw_trip[div_of(c)] | chan_trip[c]; // see RL10
    end
  end

  // division power is the plain mean of its three channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int d = 0; d < 4; d++) begin
        div_power[d] <= '0;
      end
    end else begin
      for (int d = 0; d < 4; d++) begin
        div_power[d] <= PW'(div_sum[d] / (PW+2)'(tbv_pkg::CH_PER_DIV)); // see RL6
      end
    end
  end

  // trips only outside Run; divisional bypass removes the whole division
  // only source-range bypasses feed this path, no average-power input exists
  assign div_trip = run_s2 ? 4'h0 : (div_raw_trip & ~(dbyp_s2 | sw_div_bypass)); // see RL7 RL3 RL5

  // ====================
  // voting and sealed-in actuators
  logic scram_vote;
  logic [1:0] seal, inhibit, reset_ok, latch_new;
  logic backup_seal;
  assign scram_vote = vote2(div_trip); // see RL11 RL4

  genvar a;
  generate
    for (a = 0; a < 2; a++) begin : g_act
      // reset accepted only with cause cleared and inhibit expired
      assign reset_ok[a] = rst_s2[a] && !scram_vote && !inhibit[a]; // see RL16 RL17
      assign latch_new[a] = scram_vote && !seal[a];

      tbv_inhibit_timer #(
        .CYCLES(INHIBIT_CYCLES)
      ) u_inhibit (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(latch_new[a]), // see RL19
        .busy_o(inhibit[a])
      );
    end
  endgenerate

  // one process owns both seal bits; each clears only on its own division's reset
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (rst_i) begin
        seal[k] <= 1'b0;
      end else if (scram_vote) begin
        seal[k] <= 1'b1; // see RL13 RL15
      end else if (reset_ok[k]) begin
        seal[k] <= 1'b0; // see RL15
      end
    end
  end

  // backup scram stays sealed only while both actuator divisions are sealed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      backup_seal <= 1'b0;
    end else if (scram_vote) begin
      backup_seal <= 1'b1; // see RL14
    end else if (reset_ok[0] || reset_ok[1]) begin
      backup_seal <= 1'b0;
    end
  end

  // ====================
  // outputs: primary solenoids de-energise to scram; rods need both off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_trip_o <= '0;
      load_driver_energise_o <= 2'b11;
      backup_dump_energise_o <= 1'b0;
      div_trip_o <= '0;
      transient_permissive_o <= 1'b0;
    end else begin
      primary_trip_o <= seal;
      load_driver_energise_o <= ~seal; // see RL18
      backup_dump_energise_o <= backup_seal; // see RL14
      div_trip_o <= div_trip;
      transient_permissive_o <= vote2(div_trip); // see RL9
    end
  end

  // ====================
  // interrupts: set wins over write-one clear
  logic [tbv_pkg::IRQ_W-1:0] irq_event;
  logic wr;
  assign wr = cyc_i && stb_i && we_i && !ack_o;
  assign irq_event = {byp_reject, latch_new[1], latch_new[0], backup_seal == 1'b0 && scram_vote,
                      scram_vote && !(seal[0] | seal[1])};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~((wr && adr_i == tbv_pkg::REG_INT_STATUS && sel_i[0]) ?
                     dat_i[tbv_pkg::IRQ_W-1:0] : '0)) | irq_event;
    end
  end

  assign irq_o = |(int_status & int_mask);

  // ====================
  // wishbone register access, one registered ack per request, a cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_bypass <= '0;
      sw_div_bypass <= '0;
      thresh_normal <= tbv_pkg::THRESH_NORMAL_RST;
      thresh_noncoinc <= tbv_pkg::THRESH_NONCOINC_RST;
      int_mask <= '0;
    end else if (wr) begin
      unique case (adr_i)
        tbv_pkg::REG_CH_BYPASS: begin
          if (sel_i[0]) sw_bypass[7:0] <= dat_i[7:0];
          if (sel_i[1]) sw_bypass[11:8] <= dat_i[11:8];
        end
        tbv_pkg::REG_DIV_BYPASS: begin
          if (sel_i[0]) sw_div_bypass <= dat_i[3:0];
        end
        tbv_pkg::REG_THRESH_NORMAL: begin
          if (sel_i[0]) thresh_normal[7:0] <= dat_i[7:0];
          if (sel_i[1]) thresh_normal[15:8] <= dat_i[15:8];
        end
        tbv_pkg::REG_THRESH_NONCOINC: begin
          if (sel_i[0]) thresh_noncoinc[7:0] <= dat_i[7:0];
          if (sel_i[1]) thresh_noncoinc[15:8] <= dat_i[15:8];
        end
        tbv_pkg::REG_INT_MASK: begin
          if (sel_i[0]) int_mask <= dat_i[tbv_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      unique case (adr_i)
        tbv_pkg::REG_CH_BYPASS: dat_o <= {20'h0, sw_bypass};
        tbv_pkg::REG_DIV_BYPASS: dat_o <= {28'h0, sw_div_bypass};
        tbv_pkg::REG_THRESH_NORMAL: dat_o <= {16'h0, thresh_normal};
        tbv_pkg::REG_THRESH_NONCOINC: dat_o <= {16'h0, thresh_noncoinc};
        tbv_pkg::REG_STATUS: dat_o <= {19'h0, inhibit, backup_seal, seal, div_trip, 2'h0,
                                       run_s2, nc_s2};
        tbv_pkg::REG_INT_STATUS: dat_o <= {27'h0, int_status};
        tbv_pkg::REG_INT_MASK: dat_o <= {27'h0, int_mask};
        tbv_pkg::REG_DIV_POWER01: dat_o <= 32'({div_power[1], div_power[0]});
        tbv_pkg::REG_DIV_POWER23: dat_o <= 32'({div_power[3], div_power[2]});
        tbv_pkg::REG_BYPASS_GRANT: dat_o <= {20'h0, bypass_grant};
        default: dat_o <= '0;
      endcase
    end
  end
endmodule

// ### tbv_rod_unit_model.sv
// rod hydraulic unit model driven by the two load driver outputs
module tbv_rod_unit_model (
  // solenoid supply
  input wire logic [1:0] solenoid_energise_i,
  // rod state
  output logic rod_scram_o
);
  // either energised solenoid keeps the scram valve shut
  assign rod_scram_o = ~|solenoid_energise_i;
endmodule

// ### tbv_trip_voting_checker.sv
// checker: trip voting and sealed actuator properties
module tbv_trip_voting_checker #(
  parameter longint INHIBIT_CYCLES = tbv_pkg::RESET_INHIBIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // switches
  input wire logic mode_run_i,
  input wire logic [3:0] div_bypass_sw_i,
  input wire logic [1:0] manual_reset_i,
  // actuator side
  input wire logic [1:0] primary_trip_o,
  input wire logic [1:0] load_driver_energise_o,
  input wire logic backup_dump_energise_o,
  input wire logic [3:0] div_trip_o
);
  // ====================
  // seal age
  // saturates so the counter stays small; two cycles of slack for the edge that sets it
  longint age;
  always_ff @(posedge clk_i) begin
    if (rst_i || !primary_trip_o[0]) begin
      age <= 0;
    end else if (age < INHIBIT_CYCLES) begin
      age <= age + 1;
    end
  end
  // ====================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_run_held;
    mode_run_i [*5];
  endsequence
  sequence s_reset_quiet;
    !manual_reset_i[0] [*4] ##0 primary_trip_o[0];
  endsequence
  a_load_inverse: assert property (load_driver_energise_o == ~primary_trip_o)
    else $error("load drivers differ from trips");
  a_vote_scram: assert property ($rose(primary_trip_o[0]) |-> $countones(div_trip_o) >= 2)
    else $error("seal without two divisions");
  a_both_actuators: assert property ($rose(primary_trip_o[0]) |-> primary_trip_o[1])
    else $error("actuator b missed the vote");
  a_backup_vote: assert property ($rose(backup_dump_energise_o) |-> $countones(div_trip_o) >= 2)
    else $error("backup without two divisions");
  a_seal_holds: assert property (s_reset_quiet |=> primary_trip_o[0])
    else $error("seal dropped without reset");
  a_reset_inhibit: assert property (primary_trip_o[0] && age < INHIBIT_CYCLES - 2 |=> primary_trip_o[0])
    else $error("seal cleared inside inhibit");
  a_run_no_trip: assert property (s_run_held |-> div_trip_o == 4'h0)
    else $error("trip in run mode");
  a_div_bypass: assert property (div_bypass_sw_i[0] [*5] |-> !div_trip_o[0])
    else $error("bypassed division tripped");
endmodule

bind tbv_trip_voting tbv_trip_voting_checker #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .mode_run_i(mode_run_i), .div_bypass_sw_i(div_bypass_sw_i),
  .manual_reset_i(manual_reset_i), .primary_trip_o(primary_trip_o),
  .load_driver_energise_o(load_driver_energise_o),
  .backup_dump_energise_o(backup_dump_energise_o), .div_trip_o(div_trip_o));

// ### trip_bypass_voting_logic_tb_top.sv
// testbench for the trip, bypass and voting block
module trip_bypass_voting_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [11:0] f; logic [15:0] p; logic n; logic r; logic [3:0] e;} tbv_row_s;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, run, nc, bk, perm, scram;
  logic [7:0] adr;
  logic [3:0] sel, dbyp, dtrip;
  logic [31:0] dat, dat_o, q;
  logic [11:0] flt, byp;
  logic [191:0] pwr;
  logic [1:0] mrst, trip, ld;
  int n_errors, total_checks;
  tbv_row_s rows [9] = '{
    '{12'h001, 16'h0, 1'b0, 1'b0, 4'h1}, '{12'h010, 16'h0, 1'b0, 1'b0, 4'h1},
    '{12'h002, 16'h0, 1'b0, 1'b0, 4'h2}, '{12'h800, 16'h0, 1'b0, 1'b0, 4'h8},
    '{12'h001, 16'h0, 1'b0, 1'b1, 4'h0}, '{12'h000, 16'h5000, 1'b0, 1'b0, 4'h0},
    '{12'h000, 16'h5000, 1'b1, 1'b0, 4'h1}, '{12'h000, 16'h4000, 1'b1, 1'b0, 4'h1},
    '{12'h000, 16'h3fff, 1'b1, 1'b0, 4'h0}};
  // ====================
  // design and partner
  tbv_trip_voting #(.INHIBIT_CYCLES(50)) i_tbv_trip_voting (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .irq_o(irq),
    .channel_fault_i(flt), .channel_power_i(pwr), .channel_bypass_sw_i(byp),
    .div_bypass_sw_i(dbyp), .mode_run_i(run), .noncoincident_i(nc), .manual_reset_i(mrst),
    .primary_trip_o(trip), .load_driver_energise_o(ld), .backup_dump_energise_o(bk),
    .div_trip_o(dtrip), .transient_permissive_o(perm));
  tbv_rod_unit_model i_tbv_rod_unit_model (.solenoid_energise_i(ld), .rod_scram_o(scram));
  // ====================
  // tasks
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ack is sampled before the edge's own updates land, so no race
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hf};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    if (ack !== 1'b1) begin
      n_errors++;
      complete_run;
    end
  endtask
  // ====================
  // sequence
  initial begin
    {cyc, stb, we, adr, dat, sel, flt, byp, dbyp, run, nc, mrst} = '0;
    rst_i = 1;
    pwr = '0;
    step(3);
    rst_i <= 0;
    step(1);
    chk(ld, 2'h3, "load reset");
    wb(0, tbv_pkg::REG_THRESH_NORMAL, 0); chk(q, 32'hc000, "thr normal");
    wb(0, tbv_pkg::REG_THRESH_NONCOINC, 0); chk(q, 32'h4000, "thr nc");
    wb(0, 8'hfc, 0); chk(q, 0, "unmapped");
    foreach (rows[i]) begin
      {flt, pwr[15:0], nc, run} <= {rows[i].f, rows[i].p, rows[i].n, rows[i].r};
      step(6);
      chk(dtrip, rows[i].e, "div trip");
      chk(trip, 0, "no scram");
    end
    pwr[15:0] <= 16'h0300; pwr[79:64] <= 16'h0600; pwr[143:128] <= 16'h0900;
    step(6);
    wb(0, tbv_pkg::REG_DIV_POWER01, 0); chk(q[15:0], 16'h0600, "average");
    byp <= 12'h003;
    step(4);
    flt <= 12'h003;
    step(6);
    chk(dtrip, 4'h2, "group refuse");
    wb(0, tbv_pkg::REG_BYPASS_GRANT, 0); chk(q, 32'h1, "grant");
    wb(0, tbv_pkg::REG_INT_STATUS, 0); chk(q[4], 1, "refuse event");
    flt <= 12'h011;
    step(6);
    chk(dtrip, 4'h1, "others protect");
    flt <= 0;
    step(2);
    {byp, dbyp} <= {12'h0, 4'h1};
    step(4);
    flt <= 12'h111;
    step(6);
    chk(dtrip, 4'h0, "div bypass");
    flt <= 0;
    step(2);
    dbyp <= 0;
    step(4);
    wb(1, tbv_pkg::REG_DIV_BYPASS, 32'h2);
    flt <= 12'h002;
    step(4);
    chk(dtrip, 4'h0, "sw div bypass");
    flt <= 0;
    wb(1, tbv_pkg::REG_DIV_BYPASS, 0);
    wb(1, tbv_pkg::REG_INT_MASK, 32'h1f);
    wb(1, tbv_pkg::REG_INT_STATUS, 32'h1f);
    flt <= 12'h003;
    step(6);
    chk({trip, ld, bk, perm, scram}, 7'h67, "scram");
    chk(irq, 1, "irq raise");
    wb(1, tbv_pkg::REG_INT_MASK, 0); chk(irq, 0, "irq mask");
    wb(1, tbv_pkg::REG_INT_MASK, 32'h1f); chk(irq, 1, "irq unmask");
    mrst <= 2'h3;
    step(60);
    chk(trip, 2'h3, "cause present");
    mrst <= 2'h1;
    step(4);
    flt <= 0;
    step(8);
    chk(trip, 2'h2, "reset a only");
    wb(1, tbv_pkg::REG_INT_STATUS, 32'h1f); chk(irq, 0, "irq clear");
    mrst <= 2'h2;
    step(8);
    chk({trip, ld, bk}, 5'h6, "reset b");
    mrst <= 0;
    flt <= 12'h003;
    step(6);
    {flt, mrst} <= {12'h0, 2'h3};
    step(20);
    chk(trip, 2'h3, "inhibit");
    step(24);
    chk(trip, 2'h3, "inhibit late");
    step(6);
    chk(trip, 2'h0, "inhibit over");
    flt <= 12'h003;
    step(6);
    rst_i <= 1;
    step(3);
    rst_i <= 0;
    step(1);
    chk({trip, ld}, 4'h3, "mid reset");
    step(2);
    chk(trip, 2'h3, "reseal");
    complete_run;
  end
endmodule
